// ==== rtl/mac_rx_host.sv ====
// Overview of operation
// - Register port has 32-bit data and 8-bit word address, 256 registers.
// - One register port controls both MAC and PCS logic.
// - Wait request is high during an access, low when it completes.
// - Bit 0 of write and read data is the register's least significant bit.
// - A single reset initialises all register interface logic.
// - Stream word width is a build parameter, 8 or 32 bits.
// - Delivery halts by backpressure when the FIFO reaches a programmable threshold.
// - Stream signals are sampled and driven on stream clock rising edges.
// - Valid rises only when data, markers, error and class fields are valid.
// - In 32-bit mode the earliest byte sits in bits 31:24.
// - Empty field on final word marks unused low bytes: 11, 10, 01, 00.
// - Empty field has meaning only in 32-bit word mode.
// - First marker is high with the first word of a frame.
// - Last marker is high with the final word of a frame.
// - Data pending is high whenever the FIFO holds readable data.
// - Fill high flag rises once fill level reaches the threshold.
// - Error vector with final word: collision, PHY, truncation, CRC, length, OR.
// - Class bits VLAN, broadcast, multicast, unicast held from first to last marker.
module mac_rx_host #(
    parameter int stream_word_width = 32,
    parameter int FIFO_DEPTH        = 64
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic [1:0]                        hresp,
    output logic [31:0]                       hrdata,
    input  wire logic                         rx_in_valid,
    input  wire logic [7:0]                   rx_in_byte,
    input  wire logic                         rx_in_first,
    input  wire logic                         rx_in_last,
    input  wire logic [5:0]                   rx_in_err,
    input  wire logic [3:0]                   rx_in_class,
    output logic                              rx_in_ready,
    input  wire logic                         rx_stream_clock,
    input  wire logic                         rx_sink_accept,
    output logic                              rx_word_valid,
    output logic [stream_word_width-1:0]      rx_stream_word,
    output logic [1:0]                        rx_final_word_empty_bytes,
    output logic                              rx_frame_first_marker,
    output logic                              rx_frame_last_marker,
    output logic [5:0]                        rx_err_vector,
    output logic [3:0]                        rx_frame_class,
    output logic                              rx_data_pending,
    output logic                              rx_fill_high_flag,
    output logic [15:0]                       pcs_mode
);
    localparam int W  = stream_word_width;
    localparam int NB = W / 8;
    localparam int AW = $clog2(FIFO_DEPTH);
    localparam int CW = AW + 1;
    localparam int EW = 20;

    // Refuse widths and depths the packer and pointers cannot serve
    if (!(W == 8 || W == 32)) begin : bad_width
        $error("stream_word_width must be 8 or 32");
    end
    if (FIFO_DEPTH < 4 || FIFO_DEPTH != (1 << AW) || FIFO_DEPTH > 32768) begin : bad_depth
        $error("FIFO_DEPTH must be a power of two from 4 to 32768");
    end

    mac_pkg::bus_state_t bus_state_reg;
    logic [7:0]          addr_reg;
    logic                write_reg;
    logic                en_reg;
    logic [CW-1:0]       thr_reg;
    logic [15:0]         pcs_reg;
    logic [31:0]         rd_next;
    logic                accept_a;
    logic [EW-1:0]       mem [FIFO_DEPTH];
    logic [CW-1:0]       wptr_reg;
    logic [CW-1:0]       rptr_reg;
    logic [CW-1:0]       count;
    logic [EW-1:0]       ent;
    logic                push;
    logic                pop;
    logic [W-1:0]        pack_word_reg;
    logic [2:0]          pack_cnt_reg;
    logic                pack_full_reg;
    logic                pack_first_reg;
    logic                pack_last_reg;
    logic [5:0]          pack_err_reg;
    logic [3:0]          class_reg;
    logic [2:0]          sclk_reg;
    logic [2:0]          acc_reg;
    logic                edge_s;
    logic                load_o;

    // Address phase taken only when the bus is ready
    assign accept_a  = hsel && hready && htrans[1];
    assign hreadyout = (bus_state_reg == mac_pkg::BUS_IDLE);
    assign hresp     = mac_pkg::HRESP_OKAY;

    // One wait cycle per access; hreadyout low is the wait request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_reg <= mac_pkg::BUS_IDLE;
            addr_reg      <= 8'h00;
            write_reg     <= 1'b0;
        end else begin
            case (bus_state_reg)
                mac_pkg::BUS_IDLE: begin
                    if (accept_a) begin
                        bus_state_reg <= mac_pkg::BUS_WAIT;
                        addr_reg      <= haddr[9:2];
                        write_reg     <= hwrite;
                    end
                end
                mac_pkg::BUS_WAIT: begin
                    bus_state_reg <= mac_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_reg <= mac_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Register writes land in the wait cycle, when hwdata is on the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_reg  <= mac_pkg::CTRL_EN_RST;
            thr_reg <= mac_pkg::THR_RST[CW-1:0];
            pcs_reg <= mac_pkg::PCS_RST;
        end else if (bus_state_reg == mac_pkg::BUS_WAIT && write_reg) begin
            case (addr_reg)
                mac_pkg::CTRL_IDX: en_reg  <= hwdata[mac_pkg::CTRL_EN_BIT];
                mac_pkg::THR_IDX:  thr_reg <= hwdata[CW-1:0];
                mac_pkg::PCS_IDX:  pcs_reg <= hwdata[15:0];
                default:           ;
            endcase
        end
    end
    assign pcs_mode = pcs_reg;

    // Read mux; unmapped words read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr[9:2])
            mac_pkg::CTRL_IDX: rd_next[mac_pkg::CTRL_EN_BIT] = en_reg;
            mac_pkg::THR_IDX:  rd_next[CW-1:0] = thr_reg;
            mac_pkg::STAT_IDX: begin
                rd_next[CW-1:0]                = count;
                rd_next[mac_pkg::STAT_PEND_BIT] = rx_data_pending;
                rd_next[mac_pkg::STAT_HIGH_BIT] = rx_fill_high_flag;
            end
            mac_pkg::PCS_IDX:  rd_next[15:0] = pcs_reg;
            default:           ;
        endcase
    end

    // Read data captured at the address phase, stable through the wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (accept_a && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    // Receive FIFO; writer refused at threshold, when full or disabled
    assign count       = wptr_reg - rptr_reg;
    assign rx_in_ready = en_reg && (count < thr_reg) && !count[AW];
    assign push        = rx_in_valid && rx_in_ready;
    assign ent         = mem[rptr_reg[AW-1:0]];
    assign pop         = (count != '0) && !pack_full_reg;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wptr_reg[AW-1:0]] <= {rx_in_class, rx_in_err, rx_in_first, rx_in_last,
                                      rx_in_byte};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end

    // Stream clock and accept through two flops; third flop finds the edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_reg <= 3'h0;
            acc_reg  <= 3'h0;
        end else begin
            sclk_reg <= {sclk_reg[1:0], rx_stream_clock};
            acc_reg  <= {acc_reg[1:0], rx_sink_accept};
        end
    end
    assign edge_s = sclk_reg[1] && !sclk_reg[2];
    // Accept from the pre-edge sample; the sink changes it right at the edge
    assign load_o = edge_s && (!rx_word_valid || acc_reg[2]);

    // Packer: bytes into a word, earliest byte at the top
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pack_word_reg  <= '0;
            pack_cnt_reg   <= 3'h0;
            pack_full_reg  <= 1'b0;
            pack_first_reg <= 1'b0;
            pack_last_reg  <= 1'b0;
            pack_err_reg   <= 6'h00;
            class_reg      <= 4'h0;
        end else if (load_o && pack_full_reg) begin
            pack_word_reg  <= '0;
            pack_cnt_reg   <= 3'h0;
            pack_full_reg  <= 1'b0;
            pack_first_reg <= 1'b0;
            pack_last_reg  <= 1'b0;
            pack_err_reg   <= 6'h00;
        end else if (pop) begin
            pack_word_reg[W-1-8*pack_cnt_reg -: 8] <= ent[7:0];
            pack_cnt_reg  <= pack_cnt_reg + 3'h1;
            pack_full_reg <= ent[8] || (pack_cnt_reg == 3'(NB - 1));
            if (ent[9]) begin
                pack_first_reg <= 1'b1;
                class_reg      <= ent[19:16];
            end
            if (ent[8]) begin
                pack_last_reg <= 1'b1;
                // Summary bit rebuilt here so upstream cannot get it wrong
                pack_err_reg  <= {ent[15:11], |ent[15:11]};
            end
        end
    end

    // Stream outputs change only after a detected stream clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_word_valid             <= 1'b0;
            rx_stream_word            <= '0;
            rx_final_word_empty_bytes <= 2'h0;
            rx_frame_first_marker     <= 1'b0;
            rx_frame_last_marker      <= 1'b0;
            rx_err_vector             <= 6'h00;
            rx_frame_class            <= 4'h0;
        end else if (load_o) begin
            rx_word_valid <= pack_full_reg;
            if (pack_full_reg) begin
                rx_stream_word        <= pack_word_reg;
                rx_frame_first_marker <= pack_first_reg;
                rx_frame_last_marker  <= pack_last_reg;
                rx_err_vector         <= pack_err_reg;
                rx_frame_class        <= class_reg;
                rx_final_word_empty_bytes <= (W == 32 && pack_last_reg) ?
                    2'(3'(NB) - pack_cnt_reg) : 2'h0;
            end
        end
    end

    // Level flags refreshed on each stream edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_pending   <= 1'b0;
            rx_fill_high_flag <= 1'b0;
        end else if (edge_s) begin
            rx_data_pending   <= (count != '0) || (pack_cnt_reg != 3'h0);
            rx_fill_high_flag <= (count >= thr_reg);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wait_then_done;
        !hreadyout ##1 hreadyout;
    endsequence

    bus_wait_one_a: assert property (accept_a |=> s_wait_then_done)
        else $error("access did not complete after one wait cycle");

    pcs_write_lands_a: assert property (accept_a && hwrite && haddr[9:2] == mac_pkg::PCS_IDX
        ##1 1'b1 ##1 hreadyout |-> pcs_mode == $past(hwdata[15:0]))
        else $error("PCS register write not applied");

    thr_readback_a: assert property (accept_a && !hwrite && haddr[9:2] == mac_pkg::THR_IDX
        |=> ##1 hreadyout && hrdata[CW-1:0] == thr_reg)
        else $error("threshold readback wrong");

    word_held_a: assert property (rx_word_valid && !(edge_s && acc_reg[2])
        |=> rx_word_valid && $stable(rx_stream_word) && $stable(rx_frame_last_marker))
        else $error("valid word changed without a transfer");

    err_only_last_a: assert property (rx_word_valid |-> (rx_frame_last_marker ||
        rx_err_vector == 6'h00) && rx_err_vector[0] == |rx_err_vector[5:1])
        else $error("error vector outside final word or summary bit wrong");

    empty_only_last_a: assert property (rx_word_valid && (!rx_frame_last_marker || W == 8)
        |-> rx_final_word_empty_bytes == 2'h0)
        else $error("empty field set on a non-final word");

    fill_flag_a: assert property (edge_s |=> rx_fill_high_flag ==
        ($past(count) >= $past(thr_reg)))
        else $error("fill high flag does not follow threshold");

    pending_a: assert property (edge_s && count != '0 |=> rx_data_pending)
        else $error("data pending missing while FIFO holds data");

    ready_thr_a: assert property (count >= thr_reg |-> !rx_in_ready)
        else $error("writer accepted at or above threshold");

    first_byte_top_a: assert property (pop && pack_cnt_reg == 3'h0
        |=> pack_word_reg[W-1 -: 8] == $past(ent[7:0]))
        else $error("earliest byte not in top lane");

    out_edge_only_a: assert property (!edge_s |=> $stable(rx_word_valid))
        else $error("stream valid changed away from a stream edge");
endmodule : mac_rx_host

// ==== rtl/mac_pkg.sv ====
package mac_pkg;
    // Word indices on the 8-bit register address (byte address = 4 * index)
    localparam logic [7:0]  CTRL_IDX      = 8'h00;
    localparam logic [7:0]  THR_IDX       = 8'h01;
    localparam logic [7:0]  STAT_IDX      = 8'h02;
    localparam logic [7:0]  PCS_IDX       = 8'h80;
    // Field positions
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          STAT_PEND_BIT = 16;
    localparam int          STAT_HIGH_BIT = 17;
    // Reset values
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam logic [15:0] THR_RST       = 16'h0030;
    localparam logic [15:0] PCS_RST       = 16'h0000;
    // Bus encodings
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_WAIT = 1'b1
    } bus_state_t;
endpackage : mac_pkg

// ==== verif/rx_sink_model.sv ====
module rx_sink_model (
    output logic             rx_stream_clock,
    output logic             rx_sink_accept,
    input  wire logic        stall,
    input  wire logic        rx_word_valid,
    input  wire logic [45:0] fields,
    output logic             seen,
    output logic [45:0]      cap
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] beat;
    // Start quiet so the device never sees an unknown accept
    initial begin
        rx_stream_clock = 1'b0;
        rx_sink_accept = 1'b0;
        beat = 2'h0;
        seen = 1'b0;
        cap = '0;
    end
    // Free-running stream clock, 400 ns period
    always #200 rx_stream_clock = ~rx_stream_clock;
    // Drops accept every fourth beat, so held words get exercised
    always @(posedge rx_stream_clock) begin
        beat <= beat + 2'h1;
        rx_sink_accept <= !stall && (beat != 2'h3);
    end
    // A word is taken only when valid and accept meet at an edge
    always @(posedge rx_stream_clock) begin
        seen <= rx_word_valid && rx_sink_accept;
        if (rx_word_valid && rx_sink_accept)
            cap <= fields;
    end
endmodule : rx_sink_model

// ==== verif/testbench.sv ====
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] w;
        logic [1:0]  e;
        logic        f;
        logic        l;
        logic [5:0]  er;
        logic [3:0]  c;
    } exp_t;
    logic        hclk, hresetn, hsel, hwrite, rx_in_valid, rx_in_first, rx_in_last, stall;
    logic [31:0] haddr, hwdata, hrdata, rx_stream_word, rdv;
    logic [1:0]  htrans, hresp, rx_final_word_empty_bytes;
    logic [2:0]  hsize;
    logic [7:0]  rx_in_byte;
    logic [5:0]  rx_in_err, rx_err_vector;
    logic [3:0]  rx_in_class, rx_frame_class;
    logic [15:0] pcs_mode;
    logic        hreadyout, hready, rx_in_ready, rx_stream_clock, rx_sink_accept, seen;
    logic        rx_word_valid, rx_frame_first_marker, rx_frame_last_marker;
    logic        rx_data_pending, rx_fill_high_flag;
    logic [45:0] cap;
    exp_t        exp_q[$];
    exp_t        ex, mx;
    int          bad_count, checks_done, seed;

    assign hready = hreadyout;
    mac_rx_host #(.stream_word_width(32), .FIFO_DEPTH(64)) i_dut (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .rx_in_valid, .rx_in_byte, .rx_in_first, .rx_in_last, .rx_in_err, .rx_in_class,
        .rx_in_ready, .rx_stream_clock, .rx_sink_accept, .rx_word_valid, .rx_stream_word,
        .rx_final_word_empty_bytes, .rx_frame_first_marker, .rx_frame_last_marker,
        .rx_err_vector, .rx_frame_class, .rx_data_pending, .rx_fill_high_flag, .pcs_mode);
    rx_sink_model i_sink (.rx_stream_clock, .rx_sink_accept, .stall, .rx_word_valid,
        .fields({rx_stream_word, rx_final_word_empty_bytes, rx_frame_first_marker,
                 rx_frame_last_marker, rx_err_vector, rx_frame_class}), .seen, .cap);

    always #25 hclk = ~hclk;

    task finish_test;
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    // Bounded wait for hready sampled high at a rising edge
    task wait_ready;
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 50) begin bad_count++; finish_test; end
    endtask : wait_ready

    // One single word transfer; read data lands in rdv
    task ahb(input logic [7:0] idx, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        `CHK(hreadyout, 1'b0)
        wait_ready;
        rdv = hrdata;
        `CHK(hresp, mac_pkg::HRESP_OKAY)
    endtask : ahb

    task rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] x);
        ahb(idx, 1'b0, 32'h0);
        `CHK(rdv & m, x)
    endtask : rd

    // Byte writer: held until the FIFO takes it
    task push(input logic [7:0] b, input logic f, input logic l, input logic [5:0] e,
              input logic [3:0] c);
        int n;
        rx_in_valid <= 1'b1;
        rx_in_byte <= b;
        rx_in_first <= f;
        rx_in_last <= l;
        rx_in_err <= e;
        rx_in_class <= c;
        for (n = 0; n < 3000; n++) begin
            @(posedge hclk);
            if (rx_in_ready === 1'b1) break;
        end
        if (n == 3000) begin bad_count++; finish_test; end
    endtask : push

    // Random frame; expected words noted as they are packed
    task frame(input int len, input logic [3:0] c);
        logic [7:0] b;
        logic [5:0] e;
        int         i;
        e = 6'($random(seed));
        ex = '0;
        for (i = 0; i < len; i++) begin
            b = 8'($random(seed));
            push(b, i == 0, i == len - 1, e, c);
            ex.w[31 - 8 * (i % 4) -: 8] = b;
            if (i % 4 == 3 || i == len - 1) begin
                ex.f = (i < 4);
                ex.l = (i == len - 1);
                ex.c = c;
                ex.e = ex.l ? 2'(3 - i % 4) : 2'h0;
                ex.er = ex.l ? {e[5:1], |e[5:1]} : 6'h0;
                exp_q.push_back(ex);
                ex.w = '0;
            end
        end
        rx_in_valid <= 1'b0;
        @(posedge hclk);
    endtask : frame

    task wait_drain;
        int n;
        for (n = 0; n < 4000 && exp_q.size() != 0; n++)
            @(posedge hclk);
        if (n == 4000) begin bad_count++; finish_test; end
    endtask : wait_drain

    // Unused low bytes and non-final empty codes are masked out
    always @(negedge rx_stream_clock) begin
        if (seen === 1'b1 && exp_q.size() == 0)
            `CHK(1'b0, 1'b1)
        else if (seen === 1'b1) begin
            mx = exp_q.pop_front();
            `CHK(cap & {~(32'hffffffff >> (8 * (4 - mx.e))), {2{mx.l}}, 12'hfff}, mx)
        end
    end

    initial begin
        #4000000;
        bad_count++;
        finish_test;
    end

    // Main sequence
    initial begin
        logic [31:0] d;
        int          i;
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        rx_in_valid = 1'b0;
        rx_in_byte = '0;
        rx_in_first = 1'b0;
        rx_in_last = 1'b0;
        rx_in_err = '0;
        rx_in_class = '0;
        stall = 1'b0;
        seed = 32'hf280;
        bad_count = 0;
        checks_done = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(mac_pkg::CTRL_IDX, 32'h1, 32'h1);
        rd(mac_pkg::THR_IDX, 32'h7f, 32'h30);
        rd(mac_pkg::STAT_IDX, 32'h3007f, 32'h0);
        ahb(8'h55, 1'b1, 32'hffffffff);
        rd(8'h55, 32'hffffffff, 32'h0);
        d = $random(seed);
        ahb(mac_pkg::PCS_IDX, 1'b1, d);
        `CHK(pcs_mode, d[15:0])
        rd(mac_pkg::PCS_IDX, 32'hffff, {16'h0, d[15:0]});
        for (i = 5; i <= 8; i++)
            frame(i, 4'(4'h1 << (i - 5)));
        wait_drain;
        ahb(mac_pkg::THR_IDX, 1'b1, 32'h8);
        rd(mac_pkg::THR_IDX, 32'h7f, 32'h8);
        stall <= 1'b1;
        fork
            frame(40, 4'h8);
            begin
                repeat (300) @(posedge hclk);
                `CHK(rx_in_ready, 1'b0)
                `CHK(rx_fill_high_flag, 1'b1)
                `CHK(rx_data_pending, 1'b1)
                rd(mac_pkg::STAT_IDX, 32'h30000, 32'h30000);
                stall <= 1'b0;
            end
        join
        wait_drain;
        repeat (40) @(posedge hclk);
        `CHK(rx_data_pending, 1'b0)
        `CHK(rx_fill_high_flag, 1'b0)
        ahb(mac_pkg::CTRL_IDX, 1'b1, 32'h0);
        `CHK(rx_in_ready, 1'b0)
        ahb(mac_pkg::PCS_IDX, 1'b1, 32'hffff);
        hresetn <= 1'b0;
        @(posedge hclk);
        `CHK(pcs_mode, 16'h0)
        `CHK(hreadyout, 1'b1)
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(mac_pkg::CTRL_IDX, 32'h1, 32'h1);
        finish_test;
    end
endmodule : testbench
